// ### led_driver_end.sv
// Driver end: self-timed serial receiver, forwarder and PWM
//
// How it works
// - Twelve-bit grayscale level per channel
// - Grayscale counter steps per reference tick
// - Channels turn on at count one
// - Off once count exceeds level
// - New data clear counter, force off
// - Outputs off until nonzero data latched
// - Level N gives N ticks of 4096
// - Reference tick from internal divider
// - First two rises set bit period
// - Controller period 0.33 to 10 us
// - Measurement shifts in two zeros
// - No second rise by 0.9: zero
// - Second rise before half: one
// - Controller sends 46 more bits
// - Controller ends each packet with idle
// - Packet idle locks, then forwards input
// - Controller latches after all packets
// - Latch idle copies data, starts PWM
// - Forwarded pulses regenerated locally
// - Copy only when command equals 3AAh
// - Channel fields and command bit layout
// - Packet idle 3.5 to 5.5 periods
// - Latch idle at least 8 periods
`timescale 1ns/10ps
`default_nettype none
`include "serial_pwm_defines.svh"
module led_driver_end
    import serial_pwm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // Serial link from upstream
    serial_link_if.dev link,
    // Cascade output to the next driver
    output logic serial_line_out,
    // Sink drivers, index 0 is the first channel
    output logic [2:0] channel_sink_output
);
    dev_state_t q; // Registered state
    dev_state_t d; // Next state
    logic rise; // Rising edge on the serial input
    logic gsTick; // Grayscale reference clock tick
    logic [15:0] oneLimit; // Second rise must come before this
    logic [15:0] zeroLimit; // Zero decided at this count
    logic [15:0] eosLimit; // Idle that locks the packet
    logic [15:0] latLimit; // Idle that latches the data
    logic cmdOk; // Command field matches the write command

    ////////////////////////////////////////////////////////////////////
    // Thresholds, all scaled from the measured period
    always_comb begin
        // Recomputed each cycle from the stored count
        // Half a period
        oneLimit = frac32(q.period, `ONE_LIMIT_32);
        // Nine tenths, rounded to 29/32
        zeroLimit = frac32(q.period, `ZERO_LIMIT_32);
        // Locks between 2 and 3.5 periods after the last rise
        eosLimit = frac32(q.period, `EOS_LIMIT_32);
        // Beyond the longest packet idle, short of the latch idle
        latLimit = frac32(q.period, `LAT_LIMIT_32);
    end

    // Input is synchronous, one register gives the edge
    assign rise = link.serialLine && !q.lineQ;
    // Reference clock from the local divider, none from outside
    assign gsTick = (q.gsDiv == 2'h0);
    // Upper twelve bits carry the command
    assign cmdOk =
        (q.shift[`CMD_LSB +: `GS_BITS] == `WRITE_CMD);

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        // Load request lasts a single cycle
        d.loadPulse = 1'b0;
        // Previous line level for the edge detector
        d.lineQ = link.serialLine;

        // Internal oscillator divider
        if (q.gsDiv == 2'(`GS_DIV - 1)) begin
            d.gsDiv = 2'h0;
        end else begin
            d.gsDiv = q.gsDiv + 2'h1;
        end
        // Restart the divider so count zero lasts a full tick
        if (q.loadPulse) begin
            d.gsDiv = 2'h1;
        end

        // Interval counters, clocked locally, saturating
        // A wrap would fake a short interval
        if (q.bitCnt != 16'hFFFF) begin
            d.bitCnt = q.bitCnt + 16'h0001;
        end
        if (rise) begin
            d.idleCnt = 16'h0000;
            d.armed = 1'b1;
        end else if (q.idleCnt != 16'hFFFF) begin
            d.idleCnt = q.idleCnt + 16'h0001;
        end

        // Output pulse generator, fixed width per input rise in forward mode
        if ((q.mode == DEV_FORWARD) && rise) begin
            d.outCnt = 2'(`OUT_PULSE_CYC);
            d.serialOut = 1'b1;
        end else if (q.outCnt > 2'h1) begin
            d.outCnt = q.outCnt - 2'h1;
        end else begin
            d.outCnt = 2'h0;
            d.serialOut = 1'b0;
        end

        // Receiver sequence
        unique case (q.mode)
            DEV_WAIT_FIRST: begin
                // First rise opens the period measurement
                if (rise) begin
                    d.mode = DEV_MEASURE;
                    d.bitCnt = 16'h0000;
                end
            end
            DEV_MEASURE: begin
                // Any interval is stored; the controller keeps it legal
                if (rise) begin
                    // Cycles from first to second rise
                    d.period = q.bitCnt + 16'h0001;
                    d.shift = {q.shift[45:0], 2'b00};
                    d.bitCnt = 16'h0000;
                    // Second rise opens a zero bit already counted
                    d.decided = 1'b1;
                    d.mode = DEV_DECODE;
                end
            end
            DEV_DECODE: begin
                // Rise pairs give ones, silence gives zeros
                if (rise) begin
                    if (!q.decided && (q.bitCnt < oneLimit)) begin
                        // Early second rise
                        d.shift = {q.shift[46:0], 1'b1};
                        d.decided = 1'b1;
                    end else if (q.decided) begin
                        // Start of the next bit
                        d.bitCnt = 16'h0000;
                        d.decided = 1'b0;
                    end
                    // A rise between half and 0.9 is taken as noise
                end else begin
                    // No rise this cycle
                    if (!q.decided && (q.bitCnt >= zeroLimit)) begin
                        d.shift = {q.shift[46:0], 1'b0};
                        d.decided = 1'b1;
                    end
                    // Packet idle freezes the shift register
                    if (q.idleCnt >= eosLimit) begin
                        d.mode = DEV_FORWARD;
                    end
                end
            end
            DEV_FORWARD: begin
                // Shift register frozen; pulse generator forwards
            end
        endcase

        // Latch idle, checked once per armed sequence
        // No limit exists before the first measurement
        if (q.armed && !rise && (q.idleCnt >= latLimit)
                && (q.mode != DEV_WAIT_FIRST)
                && (q.period != 16'h0000)) begin
            // Loads only on a good command, else keep old data
            d.loadPulse = cmdOk;
            d.mode = DEV_WAIT_FIRST;
            d.armed = 1'b0;
            d.decided = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register, frozen while the enable is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PWM engine; load pulse restarts its period
    pwm_engine u_pwm_engine (
        .clk(clk),
        .rst_b(rst_b),
        .en(en),
        .gsTick(gsTick),
        .load(q.loadPulse),
        .levelWord(q.shift[35:0]),
        .channel_sink_output(channel_sink_output)
    );

    // Output straight from its flip-flop
    assign serial_line_out = q.serialOut;
endmodule : led_driver_end
`default_nettype wire

// ### one_wire_rgb_pwm_driver_checker.sv
// Assertions on the serial wire and the driver outputs
`timescale 1ns/10ps
`default_nettype none
module one_wire_rgb_pwm_driver_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wire and driver outputs
    input wire logic serialLine,
    input wire logic serial_line_out,
    input wire logic [2:0] channel_sink_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] chQ; // Channels one cycle back
    logic [2:0] rise; // Channels turning on now
    assign rise = channel_sink_output & ~chQ;
    // Delay copy, plain flop keeps $past depth small
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chQ <= 3'h0;
        end else begin
            chQ <= channel_sink_output;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_hostPulse; $rose(serialLine) |=> !serialLine; endproperty
    a_hostPulse: assert property (p_hostPulse)
        else $error("controller pulse longer than one cycle");
    property p_hostQuiet;
        $rose(rst_b) |-> !serialLine ##1 !serialLine;
    endproperty
    a_hostQuiet: assert property (p_hostQuiet)
        else $error("line active right after reset");
    property p_outPulse; serial_line_out |=> !serial_line_out; endproperty
    a_outPulse: assert property (p_outPulse)
        else $error("forwarded pulse too long");
    property p_outCause;
        serial_line_out |-> $past(serialLine) || $past(serialLine, 2)
            || $past(serialLine, 3);
    endproperty
    a_outCause: assert property (p_outCause)
        else $error("forwarded pulse without input pulse");
    property p_resetOff;
        $rose(rst_b) |-> (channel_sink_output == 3'h0) [*8];
    endproperty
    a_resetOff: assert property (p_resetOff)
        else $error("channel on after reset");
    property p_onTogether; |rise |-> chQ == 3'h0; endproperty
    a_onTogether: assert property (p_onTogether)
        else $error("channel turned on outside count one");
    property p_zeroTick; |rise |-> $past(chQ) == 3'h0; endproperty
    a_zeroTick: assert property (p_zeroTick)
        else $error("count zero tick missing before turn-on");
    property p_onMin;
        |rise |=> (channel_sink_output & $past(rise)) == $past(rise);
    endproperty
    a_onMin: assert property (p_onMin)
        else $error("channel on for under one tick");
    c_fwd: cover property (serial_line_out);
    c_on: cover property (|rise);
    c_line: cover property ($rose(serialLine));
endmodule : one_wire_rgb_pwm_driver_checker
`default_nettype wire

// ### pwm_engine.sv
// Three-channel 12-bit grayscale PWM engine
`timescale 1ns/10ps
`default_nettype none
`include "serial_pwm_defines.svh"
module pwm_engine
    import serial_pwm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // Reference tick and new data
    input wire logic gsTick,
    input wire logic load,
    input wire logic [35:0] levelWord,
    // Sink drivers, high means on
    output logic [2:0] channel_sink_output
);
    pwm_state_t q; // Registered state
    pwm_state_t d; // Next state

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        if (load) begin
            // Fresh data restart the period with all outputs off
            d.counter = '0;
            d.outs = '0;
            d.level[0] = levelWord[`CH0_LSB +: `GS_BITS];
            d.level[1] = levelWord[`CH1_LSB +: `GS_BITS];
            d.level[2] = levelWord[`CH2_LSB +: `GS_BITS];
        end else if (gsTick) begin
            // Wraps after 4096 ticks, one full period
            d.counter = q.counter + 12'h001;
            for (int i = 0; i < 3; i++) begin
                // On from count one up to the level, never at zero
                d.outs[i] = (d.counter != 12'h000)
                    && (q.level[i] != 12'h000)
                    && (d.counter <= q.level[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; levels clear at power-up so all stay off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end

    assign channel_sink_output = q.outs;
endmodule : pwm_engine
`default_nettype wire

// ### serial_host_end.sv
// Controller end: AXI4-Lite registers and serial packet sender
`timescale 1ns/10ps
`default_nettype none
`include "serial_pwm_defines.svh"
module serial_host_end
    import serial_pwm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial link to the first driver
    serial_link_if.host link
);
    host_state_t q; // Registered state
    host_state_t d; // Next state
    logic [7:0] oneAt; // Second rise of a one bit
    logic [15:0] gapLen; // Idle after the last bit period

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // Bit timing; at least two cycles so the low gap shows
    always_comb begin
        oneAt = ((q.per >> 2) < 8'h02) ? 8'h02 : (q.per >> 2);
        gapLen = 16'(q.per) * (q.gapLatch ? 16'(`HOST_LAT_PERIODS - 1)
            : 16'(`HOST_EOS_PERIODS - 1));
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [31:0] m;
        m = merge(32'h0000_0000, q.wData, q.wStrb);
        d = q;
        // Write channels, either order
        if (awvalid && q.awready) begin
            d.awHeld = 1'b1;
            d.awAddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.wHeld = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (bready && q.bvalid) begin
            d.bvalid = 1'b0;
        end
        if (q.awHeld && q.wHeld && !q.bvalid) begin
            d.awHeld = 1'b0;
            d.wHeld = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            unique case (q.awAddr)
                `REG_CTRL: begin
                    if (q.wStrb[0]) begin
                        d.latchSel = q.wData[1];
                    end
                    // Start ignored while a packet is under way
                    if (m[0] && (q.mode == HOST_IDLE)) begin
                        d.mode = HOST_BIT;
                        d.sh = {q.pktHi, q.pktLo};
                        d.gapLatch = m[1];
                        d.idx = 6'h2F;
                        d.cnt = 16'h0000;
                        // Period kept inside the legal range
                        if (q.period < 8'(`TCYC_MIN_CYC)) begin
                            d.per = 8'(`TCYC_MIN_CYC);
                        end else if (q.period > 8'(`TCYC_MAX_CYC)) begin
                            d.per = 8'(`TCYC_MAX_CYC);
                        end else begin
                            d.per = q.period;
                        end
                    end
                end
                `REG_PKT_HI: d.pktHi = 16'(merge({16'h0000, q.pktHi},
                                                 q.wData, q.wStrb));
                `REG_PKT_LO: d.pktLo = merge(q.pktLo, q.wData, q.wStrb);
                `REG_PERIOD: d.period = 8'(merge({24'h0, q.period},
                                                 q.wData, q.wStrb));
                `REG_STATUS: d.bresp = `RESP_OKAY;
                default: d.bresp = `RESP_SLVERR;
            endcase
        end
        d.awready = !d.awHeld && !d.bvalid;
        d.wready = !d.wHeld && !d.bvalid;
        // Read channel, answer one cycle after the address
        if (rready && q.rvalid) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            unique case (araddr)
                `REG_CTRL: d.rdata = {30'h0, q.latchSel, 1'b0};
                `REG_PKT_HI: d.rdata = {16'h0000, q.pktHi};
                `REG_PKT_LO: d.rdata = q.pktLo;
                `REG_PERIOD: d.rdata = {24'h000000, q.period};
                `REG_STATUS: d.rdata = {31'h0, q.mode != HOST_IDLE};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `RESP_SLVERR;
                end
            endcase
        end
        d.arready = !d.rvalid;
        // Line pulse generator
        if (q.pulseCnt != 2'h0) begin
            d.pulseCnt = q.pulseCnt - 2'h1;
        end
        unique case (q.mode)
            HOST_IDLE: begin
            end
            HOST_BIT: begin
                d.cnt = q.cnt + 16'h0001;
                // Every bit opens with a rise; first two stay zero
                if ((q.cnt == 16'h0000) || ((q.cnt == 16'(oneAt))
                        && q.sh[47] && (q.idx < 6'h2E))) begin
                    d.pulseCnt = 2'(`HOST_PULSE_CYC);
                end
                if (q.cnt == 16'(q.per - 8'h01)) begin
                    d.cnt = 16'h0000;
                    if (q.idx == 6'h00) begin
                        d.mode = HOST_GAP;
                    end else begin
                        d.idx = q.idx - 6'h01;
                        d.sh = {q.sh[46:0], 1'b0};
                    end
                end
            end
            HOST_GAP: begin
                // Packet idle, or the longer latch idle when asked
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt >= gapLen - 16'h0001) begin
                    d.mode = HOST_IDLE;
                end
            end
            default: d.mode = HOST_IDLE;
        endcase
        d.line = (d.pulseCnt != 2'h0);
    end

    ////////////////////////////////////////////////////////////////////
    // State register, frozen while the enable is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            // Period starts at its nonzero default
            q.period <= `PERIOD_RESET;
        end else if (en) begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bresp = q.bresp;
    assign bvalid = q.bvalid;
    assign arready = q.arready;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign rvalid = q.rvalid;
    assign link.serialLine = q.line;
endmodule : serial_host_end
`default_nettype wire

// ### serial_link_if.sv
// The single serial wire between controller and driver
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
    logic serialLine; // Rising-edge-coded data, driven by controller
    modport host (output serialLine);
    modport dev (input serialLine);
endinterface : serial_link_if
`default_nettype wire

// ### serial_pwm_defines.svh
// Constants of the single-wire grayscale link and its PWM engine
`ifndef SERIAL_PWM_DEFINES_SVH
`define SERIAL_PWM_DEFINES_SVH
// System clock, 20 MHz
`define CLK_PERIOD_NS 50
`define CLK_KHZ 20000
// Packet layout
`define GS_BITS 12
`define PKT_BITS 48
`define CMD_LSB 36
`define CH0_LSB 24
`define CH1_LSB 12
`define CH2_LSB 0
`define WRITE_CMD 12'h3AA
// Bit period limits and their cycle counts
`define TCYC_MIN_NS 330
`define TCYC_MAX_NS 10000
`define TCYC_MIN_CYC ((`TCYC_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TCYC_MAX_CYC (`TCYC_MAX_NS / `CLK_PERIOD_NS)
// Device thresholds in 1/32 of the stored period
`define ONE_LIMIT_32 8'h10
`define ZERO_LIMIT_32 8'h1D
`define EOS_LIMIT_32 8'h60
`define LAT_LIMIT_32 8'hE0
// Host idle lengths in bit periods, rise to rise
`define HOST_EOS_PERIODS 4
`define HOST_LAT_PERIODS 9
// Pulse widths
`define HOST_PULSE_NS 14
`define HOST_PULSE_CYC ((`HOST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUT_PULSE_NS 25
`define OUT_PULSE_CYC ((`OUT_PULSE_NS < `CLK_PERIOD_NS) ? 1 : (`OUT_PULSE_NS / `CLK_PERIOD_NS))
// Grayscale reference clock divider
`define GS_OSC_KHZ 12000
`define GS_DIV ((`CLK_KHZ + `GS_OSC_KHZ - 1) / `GS_OSC_KHZ)
// Host register map
`define REG_CTRL 8'h00
`define REG_PKT_HI 8'h04
`define REG_PKT_LO 8'h08
`define REG_PERIOD 8'h0C
`define REG_STATUS 8'h10
`define PERIOD_RESET 8'h14
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### serial_pwm_pkg.sv
// Types shared by both ends of the grayscale link
package serial_pwm_pkg;
    // Receiver modes of the driver end
    typedef enum logic [1:0] {
        DEV_WAIT_FIRST, DEV_MEASURE, DEV_DECODE, DEV_FORWARD
    } dev_mode_t;
    // Sender modes of the controller end
    typedef enum logic [1:0] {HOST_IDLE, HOST_BIT, HOST_GAP} host_mode_t;
    // All state of the driver end outside the PWM engine
    typedef struct packed {
        dev_mode_t mode;
        logic lineQ;
        logic armed;
        logic decided;
        logic [15:0] period;
        logic [15:0] bitCnt;
        logic [15:0] idleCnt;
        logic [47:0] shift;
        logic [1:0] outCnt;
        logic serialOut;
        logic [1:0] gsDiv;
        logic loadPulse;
    } dev_state_t;
    // All state of the PWM engine
    typedef struct packed {
        logic [11:0] counter;
        logic [2:0][11:0] level;
        logic [2:0] outs;
    } pwm_state_t;
    // All state of the controller end
    typedef struct packed {
        logic awready, wready, arready;
        logic awHeld, wHeld;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid, rvalid;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic [15:0] pktHi;
        logic [31:0] pktLo;
        logic [7:0] period;
        logic latchSel;
        host_mode_t mode;
        logic gapLatch;
        logic [5:0] idx;
        logic [15:0] cnt;
        logic [47:0] sh;
        logic [7:0] per;
        logic [1:0] pulseCnt;
        logic line;
    } host_state_t;
    // Scale a period by k/32
    function automatic logic [15:0] frac32(input logic [15:0] t,
                                           input logic [7:0] k);
        logic [23:0] p;
        p = 24'(t) * 24'(k);
        return p[20:5];
    endfunction : frac32
endpackage : serial_pwm_pkg

// ### tb_one_wire_rgb_pwm_driver.sv
// Testbench joining the controller end and the driver end
`timescale 1ns/10ps
`default_nettype none
`include "serial_pwm_defines.svh"
module tb_one_wire_rgb_pwm_driver;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, serial_line_out;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] channel_sink_output;
    int nMismatch = 0, nChecks = 0, nOut = 0;
    serial_link_if link();
    serial_host_end u_serial_host_end (.clk(clk), .rst_b(rst_b), .en(en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .link(link));
    led_driver_end u_led_driver_end (.clk(clk), .rst_b(rst_b), .en(en),
        .link(link), .serial_line_out(serial_line_out),
        .channel_sink_output(channel_sink_output));
    one_wire_rgb_pwm_driver_checker u_one_wire_rgb_pwm_driver_checker (
        .clk(clk), .rst_b(rst_b), .serialLine(link.serialLine),
        .serial_line_out(serial_line_out),
        .channel_sink_output(channel_sink_output));
    always #25 clk = ~clk;
    // Forwarded pulse tally
    always @(posedge clk) nOut <= nOut + int'(serial_line_out);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic testDone;
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : testDone
    // One clock of a bounded wait; a hang ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 30000) begin
            chk("wait bound", 32'h1, 32'h0);
            testDone;
        end
    endtask : tick
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            tick(n);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : axr
    // Load a packet, start it, wait until the sender is idle
    task automatic sendPkt(input logic [47:0] p, input logic lat);
        logic [31:0] d;
        logic [1:0] r;
        int n = 0;
        axw(`REG_PKT_HI, 32'(p[47:32]), `RESP_OKAY);
        axw(`REG_PKT_LO, p[31:0], `RESP_OKAY);
        axw(`REG_CTRL, {30'h0, lat, 1'b1}, `RESP_OKAY);
        do begin
            axr(`REG_STATUS, d, r);
            tick(n);
        end while (d[0] !== 1'b0);
    endtask : sendPkt
    // On-time of one channel over a full turn-on, two clocks per tick
    task automatic width(input int c, input int lvl);
        int n = 0, w = 0;
        while (channel_sink_output[c] === 1'b1) tick(n);
        while (channel_sink_output[c] !== 1'b1) tick(n);
        while (channel_sink_output[c] === 1'b1) begin
            tick(n);
            w++;
        end
        chk("on cycles", 32'(w), 32'(`GS_DIV * lvl));
    endtask : width
    task automatic scenRegs;
        logic [31:0] d;
        logic [1:0] r;
        axr(`REG_PERIOD, d, r);
        chk("period reset", d, 32'(`PERIOD_RESET));
        axr(8'h20, d, r);
        chk("unmapped read", 32'(r), 32'(`RESP_SLVERR));
        axw(8'h24, 32'h0000_0001, `RESP_SLVERR);
        chk("off before data", 32'(channel_sink_output), 32'h0);
    endtask : scenRegs
    task automatic scenPwm;
        sendPkt({12'h3AA, 12'h003, 12'h000, 12'h001}, 1'b1);
        width(0, 3);
        width(2, 1);
        chk("zero level off", 32'(channel_sink_output[1]), 32'h0);
    endtask : scenPwm
    // Wrong command leaves the old levels running
    task automatic scenBadCmd;
        sendPkt({12'h155, 12'h7FF, 12'h7FF, 12'h7FF}, 1'b1);
        width(0, 3);
    endtask : scenBadCmd
    // Second packet passes through, latch takes the first
    task automatic scenCascade;
        logic [47:0] b = {12'h3AA, 12'h00A, 12'h000, 12'h005};
        int base;
        sendPkt({12'h3AA, 12'h002, 12'h000, 12'h004}, 1'b0);
        base = nOut;
        sendPkt(b, 1'b1);
        chk("forwarded", 32'(nOut - base),
            32'(`PKT_BITS + $countones(b[45:0])));
        width(0, 2);
        width(2, 4);
    endtask : scenCascade
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        scenRegs();
        scenPwm();
        scenBadCmd();
        scenCascade();
        testDone();
    end
endmodule : tb_one_wire_rgb_pwm_driver
`default_nettype wire
